// ---- hdl/trig_compare.sv ----
// Comparison core: mode decoding, hysteresis state, event output.
// Assumes sample and thresholds on the sys_clk domain.
`timescale 1ns/10ps
`include "trig_consts.svh"
module trig_compare #(
  parameter int W = 16
) (
  input  wire logic                sys_clk,
  input  wire logic                nrst,
  input  wire logic                enable,
  input  wire trig_pkg::mode_type  mode,
  input  wire logic                restart,
  input  wire logic signed [W-1:0] sample,
  input  wire logic signed [W-1:0] thr_hi,
  input  wire logic signed [W-1:0] thr_lo,
  output logic                     event_out
);
  initial begin
    if (W < 2 || W > 16) $error("trig_compare: W out of range");
  end
  // All state in one struct
  typedef struct packed {
    trig_pkg::hyst_type hy;
    logic               ev;
  } st_type;
  st_type st_reg;
  st_type st_next;
  logic   below_lo;
  logic   above_hi;
  // Threshold comparisons against converter outputs
  assign below_lo = sample < thr_lo;
  assign above_hi = sample > thr_hi;

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    st_next = st_reg;
    if (!enable || restart) begin
      // Fresh arming needed after mode change
      st_next.hy = trig_pkg::HY_IDLE;
      st_next.ev = 1'b0;
    end else begin
      unique case (mode)
        trig_pkg::MODE_BELOW: begin
          st_next.ev = sample < thr_lo;
        end
        trig_pkg::MODE_ABOVE: begin
          st_next.ev = sample > thr_hi;
        end
        trig_pkg::MODE_RISE: begin
          unique case (st_reg.hy)
            trig_pkg::HY_IDLE: if (below_lo) st_next.hy = trig_pkg::HY_ARMED;
            trig_pkg::HY_ARMED: if (above_hi) st_next.hy = trig_pkg::HY_FIRED;
            trig_pkg::HY_FIRED: if (below_lo) st_next.hy = trig_pkg::HY_ARMED;
            default: st_next.hy = trig_pkg::HY_IDLE;
          endcase
          st_next.ev = st_next.hy == trig_pkg::HY_FIRED;
        end
        trig_pkg::MODE_FALL: begin
          unique case (st_reg.hy)
            trig_pkg::HY_IDLE: if (above_hi) st_next.hy = trig_pkg::HY_ARMED;
            trig_pkg::HY_ARMED: if (below_lo) st_next.hy = trig_pkg::HY_FIRED;
            trig_pkg::HY_FIRED: if (above_hi) st_next.hy = trig_pkg::HY_ARMED;
            default: st_next.hy = trig_pkg::HY_IDLE;
          endcase
          st_next.ev = st_next.hy == trig_pkg::HY_FIRED;
        end
        trig_pkg::MODE_WIN_IN: begin
          st_next.ev = (sample > thr_lo) && (sample < thr_hi);
        end
        trig_pkg::MODE_WIN_OUT: begin
          // Exact complement of entering, so a boundary value counts as outside
          st_next.ev = !((sample > thr_lo) && (sample < thr_hi));
        end
        default: st_next.ev = 1'b0; // Unused mode codes stay quiet
      endcase
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  // Single comparison event, straight from a flip-flop
  assign event_out = st_reg.ev;

  // Rising mode: event only from armed state
  rise_arm_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (enable && !restart && mode == trig_pkg::MODE_RISE && $rose(st_reg.ev))
      |-> $past(st_reg.hy) == trig_pkg::HY_ARMED)
    else $error("rising event fired without arming");
  // Falling mode release above high
  fall_rel_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (enable && !restart && mode == trig_pkg::MODE_FALL && st_reg.ev && above_hi)
      |=> !st_reg.ev)
    else $error("falling event not released");
  // Restart clears
  restart_clr_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    restart |=> st_reg.hy == trig_pkg::HY_IDLE && !st_reg.ev)
    else $error("restart did not clear state");
  // Falling mode: first step of the event, seen at the output
  sequence fall_go_s;
    enable && !restart && mode == trig_pkg::MODE_FALL && $rose(st_reg.ev);
  endsequence
  // Falling mode: event only from armed state
  fall_arm_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    fall_go_s |-> $past(st_reg.hy) == trig_pkg::HY_ARMED)
    else $error("falling event fired without arming");
endmodule

// ---- hdl/trig_consts.svh ----
// Constants of the analog trigger detector: register offsets, field
// positions, reset values. Assumes a 32-bit AHB-Lite slave on sys_clk.
//
// Operation
// - Below-level triggers when source under level
// - Above-level triggers when source over level
// - Rising hysteresis: high=level, low=level-hyst
// - Rising asserts after below-low then above-high
// - Rising stays asserted until below low
// - Falling hysteresis: low=level, high=level+hyst
// - Falling asserts after above-high then below-low
// - Falling stays asserted until above high
// - One comparison event is the detector output
// - Window mode triggers entering or leaving region
// - Compare source against programmable threshold outputs
// - Configuring levels updates threshold converter outputs
// - Event routable to function terminals, trigger lines
`ifndef TRIG_CONSTS_SVH
`define TRIG_CONSTS_SVH
// Register byte offsets
`define OFS_CTRL      8'h00
`define OFS_LEVEL     8'h04
`define OFS_HYST      8'h08
`define OFS_TOP       8'h0C
`define OFS_BOTTOM    8'h10
`define OFS_ROUTE     8'h14
`define OFS_STATUS    8'h18
`define OFS_INT_EN    8'h1C
`define OFS_INT_CLR   8'h20
`define OFS_DAC       8'h24
// Control field positions
`define CTRL_MODE_LSB 0
`define CTRL_SRC_LSB  4
`define CTRL_EN_BIT   8
// Route field positions
`define ROUTE_PFT_LSB 0
`define ROUTE_STL_LSB 16
// Reset values
`define CTRL_RESET    32'h0000_0000
`define LEVEL_RESET   16'h0000
`endif

// ---- hdl/trig_pkg.sv ----
// Types shared by the analog trigger detector files.
// Assumes nothing beyond the constants header.
package trig_pkg;
  // Trigger mode codes as written in the control register
  typedef enum logic [2:0] {
    MODE_BELOW   = 3'h0,
    MODE_ABOVE   = 3'h1,
    MODE_RISE    = 3'h2,
    MODE_FALL    = 3'h3,
    MODE_WIN_IN  = 3'h4,
    MODE_WIN_OUT = 3'h5
  } mode_type;
  // Hysteresis arming state, Gray along idle-armed-fired
  typedef enum logic [1:0] {
    HY_IDLE  = 2'b00,
    HY_ARMED = 2'b01,
    HY_FIRED = 2'b11
  } hyst_type;
  // Threshold converter settings as a bundle
  typedef struct packed {
    logic [15:0] hi;
    logic [15:0] lo;
  } thresh_type;
endpackage

// ---- hdl/trig_top.sv ----
// Analog trigger detector top: AHB-Lite registers, threshold converter
// codes, source select, event routing and interrupt.
// Assumes an AHB-Lite master on sys_clk; samples arrive from other domains.
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "trig_consts.svh"
module trig_top #(
  parameter int W      = 16,
  parameter int N_PFT  = 16,
  parameter int N_STL  = 8
) (
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic [W-1:0]      analog_trigger_input_terminal_0,
  input  wire logic [W-1:0]      analog_trigger_input_terminal_1,
  input  wire logic [W-1:0]      programmable_gain_amplifier,
  output logic [W-1:0]           dac_hi,
  output logic [W-1:0]           dac_lo,
  output logic                   comparison_event,
  output logic [N_PFT-1:0]       programmable_function_terminal,
  output logic [N_STL-1:0]       system_trigger_line,
  output logic                   irq
);
  initial begin
    if (N_PFT > 16 || N_STL > 8) $error("trig_top: too many route lines");
  end

  ////////////////////////////////////////////////////////////////////////
  // Register state in one struct; the sample synchronisers are kept outside it
  typedef struct packed {
    logic [31:0]          ctrl;
    logic [W-1:0]         level;
    logic [W-1:0]         hyst;
    logic [W-1:0]         top;
    logic [W-1:0]         bottom;
    logic [N_PFT-1:0]     rt_pft;
    logic [N_STL-1:0]     rt_stl;
    logic [1:0]           status;
    logic [1:0]           int_en;
    logic                 irq;
    logic [N_PFT-1:0]     pft;
    logic [N_STL-1:0]     stl;
    logic [W-1:0]         dhi;
    logic [W-1:0]         dlo;
    logic                 wr_pend;
    logic [7:0]           wr_addr;
    logic [31:0]          rdata;
    logic                 restart;
    logic                 ev_d;
  } st_type;
  st_type st_reg;
  st_type st_next;
  // Synchronisers for the three analog sample buses
  logic [W-1:0] s0_a, s0_b, s1_a, s1_b, sg_a, sg_b;
  logic [W-1:0] sample;
  logic         ev;
  logic         addr_phase;
  logic [7:0]   a8;
  trig_pkg::mode_type mode;

  // Two-flop synchronisers; only stage b is read
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s0_a <= '0;
      s0_b <= '0;
      s1_a <= '0;
      s1_b <= '0;
      sg_a <= '0;
      sg_b <= '0;
    end else begin
      s0_a <= analog_trigger_input_terminal_0;
      s0_b <= s0_a;
      s1_a <= analog_trigger_input_terminal_1;
      s1_b <= s1_a;
      sg_a <= programmable_gain_amplifier;
      sg_b <= sg_a;
    end
  end

  // Source select: terminal 0, terminal 1 or amplified channel
  always_comb begin
    unique case (st_reg.ctrl[`CTRL_SRC_LSB +: 2])
      2'h0:    sample = s0_b;
      2'h1:    sample = s1_b;
      default: sample = sg_b;
    endcase
  end
  assign mode = trig_pkg::mode_type'(st_reg.ctrl[`CTRL_MODE_LSB +: 3]);

  // Comparison core against converter codes
  trig_compare #(.W(W)) u_cmp (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .enable    (st_reg.ctrl[`CTRL_EN_BIT]),
    .mode      (mode),
    .restart   (st_reg.restart),
    .sample    (sample),
    .thr_hi    (st_reg.dhi),
    .thr_lo    (st_reg.dlo),
    .event_out (ev)
  );

  assign addr_phase = hsel && hready && htrans[1];
  assign a8 = haddr[7:0];

  ////////////////////////////////////////////////////////////////////////
  // Register file, thresholds, routing, interrupt
  always_comb begin
    st_next = st_reg;
    st_next.restart = 1'b0;
    st_next.ev_d = ev;
    // Data phase of a write
    if (st_reg.wr_pend) begin
      unique case (st_reg.wr_addr)
        `OFS_CTRL: begin
          st_next.ctrl = hwdata;
          // New mode means fresh arming
          st_next.restart = hwdata[`CTRL_MODE_LSB +: 3] != st_reg.ctrl[`CTRL_MODE_LSB +: 3];
        end
        `OFS_LEVEL:  st_next.level = hwdata[W-1:0];
        `OFS_HYST:   st_next.hyst = hwdata[W-1:0];
        `OFS_TOP:    st_next.top = hwdata[W-1:0];
        `OFS_BOTTOM: st_next.bottom = hwdata[W-1:0];
        `OFS_ROUTE: begin
          st_next.rt_pft = hwdata[`ROUTE_PFT_LSB +: N_PFT];
          st_next.rt_stl = hwdata[`ROUTE_STL_LSB +: N_STL];
        end
        `OFS_INT_EN:  st_next.int_en = hwdata[1:0];
        `OFS_INT_CLR: st_next.status = st_reg.status & ~hwdata[1:0];
        default: ; // Unmapped writes ignored
      endcase
    end
    // Converter codes follow the configuration
    unique case (mode)
      trig_pkg::MODE_RISE: begin
        st_next.dhi = st_next.level;
        st_next.dlo = W'(st_next.level - st_next.hyst);
      end
      trig_pkg::MODE_FALL: begin
        st_next.dlo = st_next.level;
        st_next.dhi = W'(st_next.level + st_next.hyst);
      end
      trig_pkg::MODE_WIN_IN, trig_pkg::MODE_WIN_OUT: begin
        st_next.dhi = st_next.top;
        st_next.dlo = st_next.bottom;
      end
      default: begin
        st_next.dhi = st_next.level;
        st_next.dlo = st_next.level;
      end
    endcase
    // Event edges set sticky bits; set wins over clear
    if (ev && !st_reg.ev_d) st_next.status[0] = 1'b1;
    if (!ev && st_reg.ev_d) st_next.status[1] = 1'b1;
    // New enable counts at once, so irq always equals status and enable
    st_next.irq = |(st_next.status & st_next.int_en);
    // Route event out
    st_next.pft = st_reg.rt_pft & {N_PFT{ev}};
    st_next.stl = st_reg.rt_stl & {N_STL{ev}};
    // Address phase
    st_next.wr_pend = addr_phase && hwrite;
    st_next.wr_addr = a8;
    if (addr_phase && !hwrite) begin
      unique case (a8)
        `OFS_CTRL:   st_next.rdata = st_reg.ctrl;
        `OFS_LEVEL:  st_next.rdata = 32'(st_reg.level);
        `OFS_HYST:   st_next.rdata = 32'(st_reg.hyst);
        `OFS_TOP:    st_next.rdata = 32'(st_reg.top);
        `OFS_BOTTOM: st_next.rdata = 32'(st_reg.bottom);
        `OFS_ROUTE:  st_next.rdata = {8'h00, 8'(st_reg.rt_stl), 16'(st_reg.rt_pft)};
        `OFS_STATUS: st_next.rdata = {29'h0, ev, st_reg.status};
        `OFS_INT_EN: st_next.rdata = {30'h0, st_reg.int_en};
        `OFS_DAC:    st_next.rdata = {16'(st_reg.dhi), 16'(st_reg.dlo)};
        default:     st_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from flip-flops; hreadyout and hresp tied to constants
  assign hrdata = st_reg.rdata;
  assign hreadyout = 1'b1; // Zero-wait slave
  assign hresp = 1'b0;
  assign dac_hi = st_reg.dhi;
  assign dac_lo = st_reg.dlo;
  assign comparison_event = ev;
  assign programmable_function_terminal = st_reg.pft;
  assign system_trigger_line = st_reg.stl;
  assign irq = st_reg.irq;

  // Rising mode low threshold tracks level minus hysteresis
  rise_thr_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (mode == trig_pkg::MODE_RISE && $stable(st_reg.level) && $stable(st_reg.hyst)
     && $stable(mode)) |-> st_reg.dlo == W'(st_reg.level - st_reg.hyst))
    else $error("rising low threshold wrong");
  // Falling mode high threshold
  fall_thr_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (mode == trig_pkg::MODE_FALL && $stable(st_reg.level) && $stable(st_reg.hyst)
     && $stable(mode)) |-> st_reg.dhi == W'(st_reg.level + st_reg.hyst))
    else $error("falling high threshold wrong");
  // Route follows event one cycle later
  route_out_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    ($stable(st_reg.rt_pft)) |=> st_reg.pft == ($past(st_reg.rt_pft) & {N_PFT{$past(ev)}}))
    else $error("terminal route mismatch");
  // Interrupt raised for enabled status
  irq_lvl_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (st_reg.status[0] && st_reg.int_en[0]) |-> irq)
    else $error("irq not raised");
  // Window entering: event implies above the low threshold
  win_in_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (mode == trig_pkg::MODE_WIN_IN && ev && $stable(mode) && !st_reg.restart)
      |-> $signed($past(sample)) > $signed($past(st_reg.dlo)))
    else $error("window event outside region");
endmodule

// ---- tb/analog_src_model.sv ----
// Model of the analog side: feeds the selected sample input.
// Assumes the bench gives value and source select on sys_clk.
`timescale 1ns/10ps
module analog_src_model (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic [15:0] value,
  input  wire logic [1:0]  sel,
  output logic      [15:0] ch0,
  output logic      [15:0] ch1,
  output logic      [15:0] pga
);
  // Unselected inputs toggle every cycle, so a wrong pick shows
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ch0 <= 16'h0000;
      ch1 <= 16'h0000;
      pga <= 16'h0000;
    end else begin
      ch0 <= (sel == 2'h0) ? value : ~ch0;
      ch1 <= (sel == 2'h1) ? value : ~ch1;
      pga <= sel[1] ? value : ~pga;
    end
  end
endmodule

// ---- tb/tb.sv ----
// Bench of the analog trigger detector: bus tasks, model, checks.
// Assumes trig_top, the source model and the constants header.
`timescale 1ns/10ps
`include "trig_consts.svh"
module tb;
  logic               sys_clk = 1'b0;
  logic               nrst = 1'b0;
  logic               hsel = 1'b0;
  logic [31:0]        haddr = 32'h0;
  logic [1:0]         htrans = 2'h0;
  logic               hwrite = 1'b0;
  logic [2:0]         hsize = 3'h2;
  logic [31:0]        hwdata = 32'h0;
  logic [31:0]        hrdata;
  logic               hreadyout;
  logic               hresp;
  logic [15:0]        ch0, ch1, pga, dac_hi, dac_lo;
  logic [15:0]        val = 16'h0;
  logic [1:0]         sel = 2'h0;
  logic               ev, irq;
  logic [15:0]        pft, pm;
  logic [7:0]         stl, sm;
  int                 n_errors = 0;
  int                 cmp_count = 0;
  int                 seed = 32'h0E04;
  // Reference model state: mode, levels, arming
  logic [2:0]         md;
  logic signed [15:0] lvl, hy, top, bot;
  logic               arm, fir;
  ////////////////////////////////////////
  always #50 sys_clk = ~sys_clk;
  analog_src_model src (.sys_clk(sys_clk), .nrst(nrst), .value(val), .sel(sel),
    .ch0(ch0), .ch1(ch1), .pga(pga));
  trig_top #(.W(16), .N_PFT(16), .N_STL(8)) dut (.sys_clk(sys_clk), .nrst(nrst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .analog_trigger_input_terminal_0(ch0),
    .analog_trigger_input_terminal_1(ch1), .programmable_gain_amplifier(pga),
    .dac_hi(dac_hi), .dac_lo(dac_lo), .comparison_event(ev),
    .programmable_function_terminal(pft), .system_trigger_line(stl), .irq(irq));
  ////////////////////////////////////////
  // Verdict and end of run
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Value compare, four-state exact
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Bounded wait for hready sampled high at a rising edge
  task automatic wait_rdy();
    int i;
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (hreadyout !== 1'b1 && i < 50);
    if (hreadyout !== 1'b1) begin
      n_errors++;
      results();
    end
  endtask
  // One single word transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  // Expected event for a held sample; updates arming state
  function automatic logic expect_ev(input logic signed [15:0] v);
    logic signed [15:0] hi, lo;
    hi = (md == trig_pkg::MODE_FALL) ? lvl + hy : lvl;
    lo = (md == trig_pkg::MODE_RISE) ? lvl - hy : lvl;
    case (md)
      trig_pkg::MODE_BELOW: return v < lvl;
      trig_pkg::MODE_ABOVE: return v > lvl;
      trig_pkg::MODE_RISE: begin
        if (v < lo) begin
          fir = 1'b0;
          arm = 1'b1;
        end else if (arm && v > hi) fir = 1'b1;
        return fir;
      end
      trig_pkg::MODE_FALL: begin
        if (v > hi) begin
          fir = 1'b0;
          arm = 1'b1;
        end else if (arm && v < lo) fir = 1'b1;
        return fir;
      end
      trig_pkg::MODE_WIN_IN: return (v > bot) && (v < top);
      default: return !((v > bot) && (v < top));
    endcase
  endfunction
  // Mode change clears arming; held sample is judged afresh
  task automatic cfg(input logic [2:0] m, input logic [1:0] s);
    // Model switches first, so the new source already holds the sample
    sel <= s;
    wr(`OFS_CTRL, {23'h0, 1'b1, 2'h0, s, 1'b0, m});
    md = m;
    arm = 1'b0;
    fir = 1'b0;
    void'(expect_ev(val));
  endtask
  // Drive a sample, let it cross the sync path, check event and both route outputs
  task automatic step(input logic [15:0] v);
    logic e;
    @(posedge sys_clk);
    val <= v;
    e = expect_ev(v);
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(ev, e, "event");
    chk(pft, e ? pm : 16'h0, "terminal route");
    chk(stl, e ? sm : 8'h0, "trigger line route");
  endtask
  task automatic chk_dac(input logic [15:0] h, input logic [15:0] l);
    logic [31:0] r;
    bus(1'b0, `OFS_DAC, 32'h0, r);
    chk(r, {h, l}, "dac register");
    chk({dac_hi, dac_lo}, {h, l}, "dac codes");
  endtask
  // Hysteresis run; s is +1 for rising, -1 for falling
  task automatic hyst_run(input logic [2:0] m, input logic signed [15:0] s);
    logic [15:0] ap, fp;
    ap = 16'(lvl - s * (hy + 16'sh1));
    fp = 16'(lvl + s);
    cfg(m, 2'h1);
    chk_dac(s > 0 ? lvl : lvl + hy, s > 0 ? lvl - hy : lvl);
    step(16'(lvl + 16 * s));
    step(ap);
    step(fp);
    cfg(trig_pkg::MODE_BELOW, 2'h1);
    cfg(m, 2'h1);
    step(fp);
    step(ap);
    step(fp);
    step(16'(lvl - s));
    step(ap);
    for (int i = 0; i < 12; i++) step(16'(lvl + $random(seed) % 400));
  endtask
  ////////////////////////////////////////
  // Watchdog against a hang
  initial begin
    #2000000;
    n_errors++;
    results();
  end
  // Main sequence
  initial begin
    logic [31:0] r;
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    bus(1'b0, `OFS_CTRL, 32'h0, r);
    chk(r, `CTRL_RESET, "control reset");
    bus(1'b0, 8'h40, 32'h0, r);
    chk(r, 32'h0, "unmapped read");
    chk(hresp, 1'b0, "okay response");
    chk(ev, 1'b0, "event after reset");
    pm = 16'($random(seed));
    sm = 8'($random(seed));
    wr(`OFS_ROUTE, {8'h0, sm, pm});
    lvl = 16'sh0100;
    hy = 16'sh0;
    wr(`OFS_LEVEL, {16'h0, lvl});
    for (int i = 0; i < 3; i++) begin
      cfg(trig_pkg::MODE_ABOVE, i[1:0]);
      step(16'h0200);
      step(16'h0100);
      step(16'h0050);
    end
    $display("test source select done");
    cfg(trig_pkg::MODE_BELOW, 2'h2);
    step(lvl);
    for (int i = 0; i < 12; i++) step(16'($random(seed)));
    $display("test below level done");
    hy = {8'h0, 8'($random(seed))} | 16'sh2;
    wr(`OFS_HYST, {16'h0, hy});
    hyst_run(trig_pkg::MODE_RISE, 16'sh1);
    hyst_run(trig_pkg::MODE_FALL, -16'sh1);
    $display("test hysteresis done");
    top = lvl + 16'sh0200;
    bot = lvl - 16'sh0200;
    wr(`OFS_TOP, {16'h0, top});
    wr(`OFS_BOTTOM, {16'h0, bot});
    for (int i = 4; i < 6; i++) begin
      cfg(i[2:0], 2'h2);
      chk_dac(top, bot);
      step(16'(top + 16'sh1));
      step(16'(bot + 16'sh1));
      step(top);
      for (int j = 0; j < 8; j++) step(16'(lvl + $random(seed) % 1024));
    end
    $display("test window done");
    cfg(trig_pkg::MODE_ABOVE, 2'h0);
    step(16'(lvl - 16'sh1));
    wr(`OFS_INT_CLR, 32'h7);
    wr(`OFS_INT_EN, 32'h1);
    chk(irq, 1'b0, "irq quiet");
    step(16'(lvl + 16'sh1));
    bus(1'b0, `OFS_STATUS, 32'h0, r);
    chk(r[2:0], 3'h5, "status rose");
    chk(irq, 1'b1, "irq raised");
    wr(`OFS_INT_EN, 32'h0);
    repeat (3) @(posedge sys_clk);
    chk(irq, 1'b0, "irq masked");
    wr(`OFS_INT_CLR, 32'h1);
    bus(1'b0, `OFS_STATUS, 32'h0, r);
    chk(r[2:0], 3'h4, "status cleared");
    step(16'(lvl - 16'sh1));
    bus(1'b0, `OFS_STATUS, 32'h0, r);
    chk(r[2:0], 3'h2, "status fell");
    $display("test interrupt done");
    results();
  end
endmodule
